//--- hdl/ldm_pkg.sv
package ldm_pkg;
	// primitive cell geometry
	localparam int LDM_CELL_AW     = 4;
	localparam int LDM_CELL_DW     = 2;
	localparam int LDM_CELL_WORDS  = 16;
	localparam int LDM_CELL_BITS   = 32;
	// cascade: four cells deep, two cells wide
	localparam int LDM_DEPTH_CELLS = 4;
	localparam int LDM_WIDTH_CELLS = 2;
	localparam int LDM_AW          = 6;
	localparam int LDM_DW          = 4;
	localparam int LDM_ROW_W       = 2;
	// apb register map
	localparam int          LDM_PADDR_W    = 12;
	localparam logic [11:0] LDM_CTRL_OFS   = 12'h000;
	localparam logic [11:0] LDM_STATUS_OFS = 12'h004;
	localparam logic [11:0] LDM_WRCNT_OFS  = 12'h008;
	// control register fields
	localparam int          LDM_CTRL_W       = 3;
	localparam int          LDM_CTRL_SP_REG  = 0;
	localparam int          LDM_CTRL_DP_REG  = 1;
	localparam int          LDM_CTRL_ROM_REG = 2;
	localparam logic [2:0]  LDM_CTRL_RST     = 3'h0;
	// status register fields
	localparam int          LDM_STAT_SP_LSB  = 0;
	localparam int          LDM_STAT_DP_LSB  = 4;
	localparam int          LDM_STAT_ROM_LSB = 8;
	// write counter
	localparam int          LDM_WRCNT_W   = 16;
	localparam logic [15:0] LDM_WRCNT_RST = 16'h0000;
	// rom image: only the first eight words are given, the rest stay zero
	localparam logic [31:0]  LDM_ROM_HEAD  = 32'hC3A5_96F1;
	localparam logic [255:0] LDM_ROM_IMAGE = {224'h0, LDM_ROM_HEAD};
endpackage : ldm_pkg

//--- hdl/ldm_cell.sv
`timescale 1ns/1ps
// one 16x2 lookup-table memory cell with a synchronous write port
module ldm_cell
	import ldm_pkg::*;
#(
	parameter logic [LDM_CELL_BITS-1:0] INIT_BITS = '0
) (
	input  wire logic                   mclk,
	input  wire logic                   writeEn,
	input  wire logic [LDM_CELL_AW-1:0] writeSel,
	input  wire logic [LDM_CELL_DW-1:0] writeWord,
	input  wire logic [LDM_CELL_AW-1:0] readSel,
	output logic      [LDM_CELL_DW-1:0] readWord
);
	// power-on contents, bit by bit; unset bits default to zero
	// given at the declaration so the write process stays the only writer
	logic [LDM_CELL_WORDS-1:0][LDM_CELL_DW-1:0] mem_q = INIT_BITS;

	// write at the rising edge only while enabled; no reset on contents
	always_ff @(posedge mclk) begin
		if (writeEn) begin
			mem_q[writeSel] <= writeWord;
		end
	end

	// asynchronous read port
	assign readWord = mem_q[readSel];

	logic [LDM_CELL_DW-1:0] heldWord;
	assign heldWord = mem_q[writeSel];

	cellWrite_a: assert property (@(posedge mclk)
		writeEn |=> heldWord == $past(writeWord) || writeSel != $past(writeSel))
		else $error("cell word not updated by write");
	cellHold_a: assert property (@(posedge mclk)
		!writeEn && $stable(writeSel) ##1 $stable(writeSel) |-> $stable(heldWord))
		else $error("cell word changed without write enable");
endmodule : ldm_cell

//--- hdl/ldm_top.sv
`timescale 1ns/1ps
// cascaded lut memories: single-port ram, dual-port ram and rom, apb config
module ldm_top
	import ldm_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// single-port ram
	input  wire logic              primitiveWriteEnable,
	input  wire logic [LDM_AW-1:0] spLocation,
	input  wire logic [LDM_DW-1:0] spWriteWord,
	input  wire logic              outputStageEnable,
	output logic      [LDM_DW-1:0] spReadWord,
	// dual-port ram
	input  wire logic              dpWriteEnable,
	input  wire logic              writeSideClockEnable,
	input  wire logic [LDM_AW-1:0] writeWordSelect,
	input  wire logic [LDM_DW-1:0] dpWriteWord,
	input  wire logic [LDM_AW-1:0] readWordSelect,
	input  wire logic              readSideClockEnable,
	output logic      [LDM_DW-1:0] dualReadWord,
	// rom
	input  wire logic [LDM_AW-1:0] romLocation,
	input  wire logic              romOutputClockEnable,
	output logic      [LDM_DW-1:0] romReadWord
);
	logic [LDM_CTRL_W-1:0]  ctrl_q, ctrl_d;
	logic [LDM_WRCNT_W-1:0] wrCnt_q, wrCnt_d;
	logic [31:0]            prdata_q, prdata_d;
	logic                   pready_q, pready_d;
	logic                   pslverr_q, pslverr_d;
	logic [LDM_DW-1:0]      spOut_q, spOut_d;
	logic [LDM_DW-1:0]      dpOut_q, dpOut_d;
	logic [LDM_DW-1:0]      romOut_q, romOut_d;

	logic [LDM_DEPTH_CELLS-1:0][LDM_DW-1:0] spRow;
	logic [LDM_DEPTH_CELLS-1:0][LDM_DW-1:0] dpRow;
	logic [LDM_DEPTH_CELLS-1:0][LDM_DW-1:0] romRow;
	logic [LDM_DW-1:0] spComb;
	logic [LDM_DW-1:0] dpComb;
	logic [LDM_DW-1:0] romComb;
	logic              dpWriteTaken;
	logic              apbAccess;
	logic              apbWrite;

	// slice of the rom image for one cell of the cascade
	function automatic logic [LDM_CELL_BITS-1:0] cellImage(input int row, input int col);
		logic [LDM_CELL_BITS-1:0] bits;
		bits = '0;
		for (int w = 0; w < LDM_CELL_WORDS; w++) begin
			bits[w*LDM_CELL_DW +: LDM_CELL_DW] =
				LDM_ROM_IMAGE[(row*LDM_CELL_WORDS + w)*LDM_DW + col*LDM_CELL_DW +: LDM_CELL_DW];
		end
		return bits;
	endfunction : cellImage

	// dual-port write needs both enables
	assign dpWriteTaken = dpWriteEnable & writeSideClockEnable;

	// cascade: upper address bits pick a row, each row is two cells wide
	for (genvar r = 0; r < LDM_DEPTH_CELLS; r++) begin : gRow
		for (genvar c = 0; c < LDM_WIDTH_CELLS; c++) begin : gCol
			ldm_cell #(
				.INIT_BITS ('0)
			) uSp (
				.mclk      (mclk),
				.writeEn   (primitiveWriteEnable &&
				            spLocation[LDM_AW-1:LDM_CELL_AW] == LDM_ROW_W'(r)),
				.writeSel  (spLocation[LDM_CELL_AW-1:0]),
				.writeWord (spWriteWord[c*LDM_CELL_DW +: LDM_CELL_DW]),
				.readSel   (spLocation[LDM_CELL_AW-1:0]),
				.readWord  (spRow[r][c*LDM_CELL_DW +: LDM_CELL_DW])
			);
			ldm_cell #(
				.INIT_BITS ('0)
			) uDp (
				.mclk      (mclk),
				.writeEn   (dpWriteTaken &&
				            writeWordSelect[LDM_AW-1:LDM_CELL_AW] == LDM_ROW_W'(r)),
				.writeSel  (writeWordSelect[LDM_CELL_AW-1:0]),
				.writeWord (dpWriteWord[c*LDM_CELL_DW +: LDM_CELL_DW]),
				.readSel   (readWordSelect[LDM_CELL_AW-1:0]),
				.readWord  (dpRow[r][c*LDM_CELL_DW +: LDM_CELL_DW])
			);
			// rom: same cell with its write port held off
			ldm_cell #(
				.INIT_BITS (cellImage(r, c))
			) uRom (
				.mclk      (mclk),
				.writeEn   (1'b0),
				.writeSel  (romLocation[LDM_CELL_AW-1:0]),
				.writeWord ('0),
				.readSel   (romLocation[LDM_CELL_AW-1:0]),
				.readWord  (romRow[r][c*LDM_CELL_DW +: LDM_CELL_DW])
			);
		end
	end

	// row selection of the combinational read words
	assign spComb  = spRow[spLocation[LDM_AW-1:LDM_CELL_AW]];
	assign dpComb  = dpRow[readWordSelect[LDM_AW-1:LDM_CELL_AW]];
	assign romComb = romRow[romLocation[LDM_AW-1:LDM_CELL_AW]];

	// optional output stages; reset clears them but leaves the arrays alone
	always_comb begin
		spOut_d  = outputStageEnable    ? spComb  : spOut_q;
		dpOut_d  = readSideClockEnable  ? dpComb  : dpOut_q;
		romOut_d = romOutputClockEnable ? romComb : romOut_q;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			spOut_q  <= '0;
			dpOut_q  <= '0;
			romOut_q <= '0;
		end else begin
			spOut_q  <= spOut_d;
			dpOut_q  <= dpOut_d;
			romOut_q <= romOut_d;
		end
	end

	// read words bypass the stage when it is off: this path is unregistered
	assign spReadWord   = ctrl_q[LDM_CTRL_SP_REG]  ? spOut_q  : spComb;
	assign dualReadWord = ctrl_q[LDM_CTRL_DP_REG]  ? dpOut_q  : dpComb;
	assign romReadWord  = ctrl_q[LDM_CTRL_ROM_REG] ? romOut_q : romComb;

	// apb: one wait state, the answer comes at the second access cycle
	assign apbAccess = psel & penable & pready_q;
	assign apbWrite  = apbAccess & pwrite;

	always_comb begin
		pready_d  = psel & penable & ~pready_q;
		prdata_d  = 32'h0000_0000;
		pslverr_d = 1'b0;
		if (pready_d) begin
			case (paddr)
				LDM_CTRL_OFS: begin
					prdata_d[LDM_CTRL_W-1:0] = ctrl_q;
				end
				LDM_STATUS_OFS: begin
					prdata_d[LDM_STAT_SP_LSB +: LDM_DW]  = spReadWord;
					prdata_d[LDM_STAT_DP_LSB +: LDM_DW]  = dualReadWord;
					prdata_d[LDM_STAT_ROM_LSB +: LDM_DW] = romReadWord;
				end
				LDM_WRCNT_OFS: begin
					prdata_d[LDM_WRCNT_W-1:0] = wrCnt_q;
				end
				default: begin
					pslverr_d = 1'b1; // unmapped: error, data zero
				end
			endcase
		end
	end

	// control and write counter; a counted write wins over a clearing access
	always_comb begin
		ctrl_d  = ctrl_q;
		wrCnt_d = wrCnt_q;
		if (apbWrite && paddr == LDM_CTRL_OFS) begin
			ctrl_d = pwdata[LDM_CTRL_W-1:0];
		end
		if (apbWrite && paddr == LDM_WRCNT_OFS) begin
			wrCnt_d = LDM_WRCNT_RST;
		end
		wrCnt_d = wrCnt_d + LDM_WRCNT_W'(primitiveWriteEnable) + LDM_WRCNT_W'(dpWriteTaken);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q    <= LDM_CTRL_RST;
			wrCnt_q   <= LDM_WRCNT_RST;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			wrCnt_q   <= wrCnt_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// helpers for the checks below
	logic [LDM_DW-1:0] romExpect;
	assign romExpect = LDM_ROM_IMAGE[{romLocation, 2'b00} +: LDM_DW];

	sequence spWriteSeq;
		primitiveWriteEnable && !ctrl_q[LDM_CTRL_SP_REG];
	endsequence
	sequence spSameWord;
		$stable(spLocation) && $stable(ctrl_q);
	endsequence
	sequence dpWriteSeq;
		dpWriteEnable && writeSideClockEnable && !ctrl_q[LDM_CTRL_DP_REG];
	endsequence

	spWriteRead_a: assert property (@(posedge mclk) disable iff (rst)
		spWriteSeq ##1 spSameWord |-> spReadWord == $past(spWriteWord))
		else $error("single-port read missed the written word");
	spNoWrite_a: assert property (@(posedge mclk) disable iff (rst)
		!primitiveWriteEnable && !ctrl_q[LDM_CTRL_SP_REG] ##1 spSameWord
		|-> $stable(spReadWord))
		else $error("single-port word changed without write enable");
	spStageHold_a: assert property (@(posedge mclk) disable iff (rst)
		ctrl_q[LDM_CTRL_SP_REG] && !outputStageEnable ##1 $stable(ctrl_q)
		|-> $stable(spReadWord))
		else $error("single-port stage moved while disabled");
	stageReset_a: assert property (@(posedge mclk)
		rst |=> spOut_q == '0 && dpOut_q == '0 && romOut_q == '0)
		else $error("output stages not cleared by reset");
	dpWriteRead_a: assert property (@(posedge mclk) disable iff (rst)
		dpWriteSeq ##1 ($stable(ctrl_q) && readWordSelect == $past(writeWordSelect))
		|-> dualReadWord == $past(dpWriteWord))
		else $error("dual-port read missed the word just written");
	dpWriteGate_a: assert property (@(posedge mclk) disable iff (rst)
		!writeSideClockEnable && !ctrl_q[LDM_CTRL_DP_REG] ##1
		($stable(readWordSelect) && $stable(ctrl_q)) |-> $stable(dualReadWord))
		else $error("dual-port write taken without write-side enable");
	dpReadStage_a: assert property (@(posedge mclk) disable iff (rst)
		ctrl_q[LDM_CTRL_DP_REG] && readSideClockEnable ##1 $stable(ctrl_q)
		|-> dualReadWord == $past(dpComb))
		else $error("dual-port read stage did not load");
	romDirect_a: assert property (@(posedge mclk) disable iff (rst)
		!ctrl_q[LDM_CTRL_ROM_REG] |-> romReadWord == romExpect)
		else $error("rom word differs from image");
	romStage_a: assert property (@(posedge mclk) disable iff (rst)
		ctrl_q[LDM_CTRL_ROM_REG] && romOutputClockEnable ##1 $stable(ctrl_q)
		|-> romReadWord == $past(romExpect))
		else $error("rom output stage did not load the image word");
	ctrlWrite_a: assert property (@(posedge mclk) disable iff (rst)
		apbWrite && paddr == LDM_CTRL_OFS |=> ctrl_q == $past(pwdata[LDM_CTRL_W-1:0]))
		else $error("control write not taken");
endmodule : ldm_top

//--- sim/ldm_fabric.sv
`timescale 1ns/1ps
// fabric-side partner: drives every memory input and holds it a whole cycle
module ldm_fabric
	import ldm_pkg::*;
(
	output logic              primitiveWriteEnable,
	output logic [LDM_AW-1:0] spLocation,
	output logic [LDM_DW-1:0] spWriteWord,
	output logic              outputStageEnable,
	output logic              dpWriteEnable,
	output logic              writeSideClockEnable,
	output logic [LDM_AW-1:0] writeWordSelect,
	output logic [LDM_DW-1:0] dpWriteWord,
	output logic [LDM_AW-1:0] readWordSelect,
	output logic              readSideClockEnable,
	output logic [LDM_AW-1:0] romLocation,
	output logic              romOutputClockEnable
);
	// quiet start so no write can fire before the first command
	initial begin
		{primitiveWriteEnable, outputStageEnable, dpWriteEnable} = '0;
		{writeSideClockEnable, readSideClockEnable, romOutputClockEnable} = '0;
		{spLocation, writeWordSelect, readWordSelect, romLocation} = '0;
		{spWriteWord, dpWriteWord} = '0;
	end

	// call just after a rising edge; values stand until the next call
	task sp(input logic we, input logic [5:0] a, input logic [3:0] d, input logic ce);
		primitiveWriteEnable <= we;
		spLocation           <= a;
		spWriteWord          <= d;
		outputStageEnable    <= ce;
	endtask : sp

	// write and read sides move together but address separate words
	task dp(input logic we, input logic wce, input logic [5:0] wa, input logic [3:0] d,
		input logic [5:0] ra, input logic rce);
		dpWriteEnable        <= we;
		writeSideClockEnable <= wce;
		writeWordSelect      <= wa;
		dpWriteWord          <= d;
		readWordSelect       <= ra;
		readSideClockEnable  <= rce;
	endtask : dp

	// rom address and output stage enable
	task rom(input logic [5:0] a, input logic ce);
		romLocation          <= a;
		romOutputClockEnable <= ce;
	endtask : rom
endmodule : ldm_fabric

//--- sim/ldm_top_tb.sv
`timescale 1ns/1ps
// bench for the cascaded lut memories and their apb control
module ldm_top_tb
	import ldm_pkg::*;
;
	logic              mclk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, rdv;
	logic              primitiveWriteEnable, outputStageEnable, dpWriteEnable;
	logic              writeSideClockEnable, readSideClockEnable, romOutputClockEnable;
	logic [LDM_AW-1:0] spLocation, writeWordSelect, readWordSelect, romLocation;
	logic [LDM_DW-1:0] spWriteWord, spReadWord, dpWriteWord, dualReadWord, romReadWord;
	int                miscompares, checks;

	ldm_top DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .primitiveWriteEnable, .spLocation, .spWriteWord, .outputStageEnable,
		.spReadWord, .dpWriteEnable, .writeSideClockEnable, .writeWordSelect, .dpWriteWord,
		.readWordSelect, .readSideClockEnable, .dualReadWord, .romLocation,
		.romOutputClockEnable, .romReadWord);
	ldm_fabric fab (.primitiveWriteEnable, .spLocation, .spWriteWord, .outputStageEnable,
		.dpWriteEnable, .writeSideClockEnable, .writeWordSelect, .dpWriteWord,
		.readWordSelect, .readSideClockEnable, .romLocation, .romOutputClockEnable);

	// 4 ns clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// row bits change the pattern, so a wrong row decode shows
	function automatic logic [3:0] pat(input int a);
		return 4'(a + (a >> 4) * 5);
	endfunction : pat
	function automatic logic [3:0] dpat(input int a);
		return ~pat(a);
	endfunction : dpat
	function automatic logic [3:0] romw(input int a);
		return (a < 8) ? LDM_ROM_HEAD[a*4 +: 4] : 4'h0;
	endfunction : romw

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// apb transfer; waits for pready, only the watchdog ends a hang
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// three enabled-stage outputs compared in one place
	task look(input int s, input int r);
		#1;
		chk(spReadWord, pat(s));
		chk(dualReadWord, dpat(s));
		chk(romReadWord, romw(r));
	endtask : look

	task stop_test;
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	// watchdog: the run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge mclk);
		miscompares++;
		stop_test();
	end

	// main sequence
	initial begin
		miscompares = 0;
		checks = 0;
		{rst, psel, penable, pwrite} = 4'b1000;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		apb(1'b0, LDM_CTRL_OFS, 32'h0);
		chk(rdv, 32'(LDM_CTRL_RST));
		apb(1'b0, 12'h00C, 32'h0);
		chk(err, 1'b1); // unmapped word
		chk(rdv, 32'h0000_0000); // unmapped word
		// power-on image through the unregistered paths
		for (int a = 0; a < 64; a++) begin
			@(posedge mclk);
			fab.sp(1'b0, 6'(a), 4'h0, 1'b0);
			fab.dp(1'b0, 1'b0, 6'(a), 4'h0, 6'(a), 1'b0);
			fab.rom(6'(a), 1'b0);
			#1;
			chk(spReadWord, 4'h0);
			chk(dualReadWord, 4'h0);
			chk(romReadWord, romw(a));
		end
		// write every word, then a blocked write of zero to the same word
		for (int a = 0; a < 64; a++) begin
			@(posedge mclk);
			fab.sp(1'b1, 6'(a), pat(a), 1'b0);
			fab.dp(1'b1, 1'b1, 6'(a), dpat(a), 6'(a), 1'b0);
			@(posedge mclk);
			fab.sp(1'b0, 6'(a), 4'h0, 1'b0);
			fab.dp(a[0], ~a[0], 6'(a), 4'h0, 6'(a), 1'b0);
			#1;
			chk(spReadWord, pat(a));
			chk(dualReadWord, dpat(a));
			// the blocked write is taken at this edge if the gating is broken
			@(posedge mclk);
			#1;
			chk(spReadWord, pat(a));
			chk(dualReadWord, dpat(a));
		end
		apb(1'b0, LDM_WRCNT_OFS, 32'h0);
		chk(rdv, 32'h0000_0080);
		apb(1'b1, LDM_WRCNT_OFS, 32'h0000_0000);
		apb(1'b0, LDM_WRCNT_OFS, 32'h0000_0000);
		chk(rdv, 32'h0000_0000);
		// registered outputs: one enabled edge loads, disabled edges hold
		apb(1'b1, LDM_CTRL_OFS, 32'h0000_0007);
		@(posedge mclk);
		fab.sp(1'b0, 6'd9, 4'h0, 1'b1);
		fab.dp(1'b0, 1'b0, 6'd0, 4'h0, 6'd9, 1'b1);
		fab.rom(6'd3, 1'b1);
		@(posedge mclk);
		fab.sp(1'b0, 6'd10, 4'h0, 1'b0);
		fab.dp(1'b0, 1'b0, 6'd0, 4'h0, 6'd10, 1'b0);
		fab.rom(6'd4, 1'b0);
		look(9, 3);
		@(posedge mclk);
		look(9, 3);
		// reset clears stages and control but leaves the stored words
		@(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		apb(1'b0, LDM_CTRL_OFS, 32'h0000_0000);
		chk(rdv, 32'(LDM_CTRL_RST));
		apb(1'b1, LDM_CTRL_OFS, 32'h0000_0007);
		#1;
		chk({spReadWord, dualReadWord, romReadWord}, 12'h000);
		apb(1'b1, LDM_CTRL_OFS, 32'h0);
		#1;
		chk({spReadWord, dualReadWord}, {pat(10), dpat(10)});
		apb(1'b0, LDM_STATUS_OFS, 32'h0000_0000);
		chk(rdv, {20'h0_0000, romw(4), dpat(10), pat(10)});
		stop_test();
	end
endmodule : ldm_top_tb
